// [tcb_pkg.sv]
/*
  Package for the 8-bit timer/counter with event input, toggle and PWM output.
  Assumes a 200 MHz system clock and an Avalon-MM slave port with 32-bit data.
*/
package tcb_pkg;

  // Printed register indexes; byte address is four times the index
  localparam logic [7:0] IDX_RELOAD = 8'hCD;
  localparam logic [7:0] IDX_MODE = 8'hDA;
  localparam logic [7:0] IDX_COUNT = 8'hDB;
  localparam logic [7:0] IDX_FLAGS = 8'hC0;
  localparam int ADDR_W = 10;

  // Mode register fields
  localparam int MODE_RUN = 7;
  localparam int MODE_PRE_HI = 6;
  localparam int MODE_PRE_LO = 4;
  localparam int MODE_CKS = 3;
  localparam int MODE_ALOAD = 2;
  localparam int MODE_TOGGLE = 1;
  localparam int MODE_PWM = 0;

  // Flag register fields
  localparam int FLG_OVF = 0;
  localparam int FLG_IEN = 1;
  localparam int FLG_PIN = 2;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Overflow boundary masks (counts 256, 64, 32, 16)
  localparam logic [7:0] MASK_256 = 8'hFF;
  localparam logic [7:0] MASK_64 = 8'h3F;
  localparam logic [7:0] MASK_32 = 8'h1F;
  localparam logic [7:0] MASK_16 = 8'h0F;

  // Prescaler: code 0 divides by 256, code 7 by 2
  localparam int PRE_W = 8;
  localparam logic [7:0] PRE_FULL = 8'hFF;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } tcb_avm_req_t;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } tcb_avm_rsp_t;

  typedef struct packed {
    logic gpioLevel;
    logic gpioDrive;
  } tcb_gpio_t;

  typedef struct packed {
    logic level;
    logic drive;
  } tcb_pin_t;

endpackage : tcb_pkg

// [tcb_prescaler.sv]
/*
  Free-running prescaler giving a one-cycle tick at clk_sys / 2^(8-code).
  Assumes a synchronous active-high reset and a clear while the timer is off.
*/
`timescale 1ns/1ps
module tcb_prescaler #(
  parameter int WIDTH = tcb_pkg::PRE_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire logic [2:0] rateCode,
  // Tick
  output logic tick
);

  // Refused at elaboration; the mask logic is sized for eight bits
  if (WIDTH != 8)
  begin : g_width_check
    $error("tcb_prescaler supports WIDTH 8 only");
  end

  typedef struct packed {
    logic [WIDTH-1:0] div;
  } tcb_pre_state_t;

  tcb_pre_state_t state_q;
  tcb_pre_state_t state_d;
  logic [WIDTH-1:0] mask;

  always_comb
  begin
    state_d = state_q;
    mask = tcb_pkg::PRE_FULL >> rateCode; // [RULE3]
    if (clear)
      state_d.div = '0;
    else
      state_d.div = state_q.div + 8'h01;
  end

  // Tick while all bits under the selected ratio are ones
  assign tick = ((state_q.div & mask) == mask) && !clear; // [RULE3]

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state_q <= '0;
    else
      state_q <= state_d;
  end

endmodule : tcb_prescaler

// [tcb_event_sync.sv]
/*
  Two-flop synchroniser and falling-edge detector for the event input pin.
  Assumes the pin is asynchronous to clk_sys and pulses last over two cycles.
*/
`timescale 1ns/1ps
module tcb_event_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pin
  input wire logic eventPin,
  // Edge
  output logic fallPulse
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } tcb_sync_state_t;

  tcb_sync_state_t state_q;
  tcb_sync_state_t state_d;

  // First flop feeds only the second
  always_comb
  begin
    state_d = state_q;
    state_d.meta = eventPin; // [RULE21]
    state_d.sync = state_q.meta;
    state_d.prev = state_q.sync;
  end

  assign fallPulse = state_q.prev && !state_q.sync; // [RULE21]

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state_q <= 3'b111;
    else
      state_q <= state_d;
  end

endmodule : tcb_event_sync

// [tcb_timer.sv]
/*
  8-bit up timer/event counter with double-buffered reload, toggle and PWM
  output on a shared pin, and an Avalon-MM register slave.
  Assumes a single 200 MHz clock, synchronous reset, and a GPIO block that
  supplies the pin's level and drive when the timer does not own it.
*/
// The Avalon-MM register port was chosen for this implementation.
// Functional notes
// [RULE1] Enable bit 7 stops or runs counter
// [RULE2] Bit 3 picks prescaler or event pin
// [RULE3] Rate code 000 divides 256, 111 divides 2
// [RULE4] Overflow sets flag until software clears
// [RULE5] Overflow reloads counter from active reload; the code loads reloadHold, which becomes active at that same overflow
// [RULE6] Reload writes buffered until next overflow
// [RULE7] Software configures mode before enabling
// [RULE8] Software writes counter equal reload first
// [RULE9] PWM pair picks 256/64/32/16 boundary
// [RULE10] Auto-reload bit only without PWM
// [RULE11] Toggle bit inverts pin each overflow
// [RULE12] Toggle off returns pin to GPIO
// [RULE13] PWM bit drives waveform onto pin
// [RULE14] Software keeps PWM off when toggling
// [RULE15] Event mode counts falling edges, wraps overflow
// [RULE16] Event mode disables pin wake-up
// [RULE17] Event mode holds pin interrupt flag zero
// [RULE18] Overflow flag and request during outputs
// [RULE19] PWM high until count equals reload
// [RULE20] Timer overflow never wakes the system
// [RULE21] Event pin synchronised before edge detection
`timescale 1ns/1ps
module tcb_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM slave
  input wire tcb_pkg::tcb_avm_req_t avmReq,
  output tcb_pkg::tcb_avm_rsp_t avmRsp,
  // Event input and GPIO hand-off
  input wire logic eventPin,
  input wire tcb_pkg::tcb_gpio_t gpio,
  // Shared output pin
  output tcb_pkg::tcb_pin_t sharedPin,
  // Requests to the system
  output logic overflowIrq,
  output logic eventPinIrq,
  output logic wakeReq
);

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] count;
    logic [7:0] reloadHold;
    logic [7:0] reloadActive;
    logic ovfFlag;
    logic ovfIen;
    logic pinFlag;
    logic toggleLvl;
    logic pwmLvl;
    logic runPrev;
    logic ack;
    logic [31:0] rdata;
  } tcb_state_t;

  tcb_state_t state_q;
  tcb_state_t state_d;

  logic running;
  logic extClock;
  logic pwmOn;
  logic toggleOn;
  logic reloadOn;
  logic [2:0] rate;
  logic preTick;
  logic evFall;
  logic countTick;
  logic [7:0] bound;
  logic overflow;
  logic busReq;
  logic wrEn;
  logic [7:0] wrByte;
  logic [7:0] wordIdx;
  logic aligned;

  function automatic logic [7:0] boundMask(input logic pwm, input logic [1:0] sel);
    logic [7:0] m;
    m = tcb_pkg::MASK_256;
    if (pwm)
    begin
      unique case (sel)
        2'b00: m = tcb_pkg::MASK_256;
        2'b01: m = tcb_pkg::MASK_64;
        2'b10: m = tcb_pkg::MASK_32;
        2'b11: m = tcb_pkg::MASK_16;
      endcase
    end
    return m;
  endfunction : boundMask

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
    return (a & m) == (b & m);
  endfunction : hit

  assign running = state_q.mode[tcb_pkg::MODE_RUN];
  assign extClock = state_q.mode[tcb_pkg::MODE_CKS];
  assign pwmOn = state_q.mode[tcb_pkg::MODE_PWM];
  assign toggleOn = state_q.mode[tcb_pkg::MODE_TOGGLE] && !pwmOn;
  assign reloadOn = pwmOn || state_q.mode[tcb_pkg::MODE_ALOAD]; // [RULE10]
  assign rate = state_q.mode[tcb_pkg::MODE_PRE_HI:tcb_pkg::MODE_PRE_LO];

  tcb_prescaler #(
    .WIDTH(tcb_pkg::PRE_W)
  ) u_pre (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(!running || extClock),
    .rateCode(rate),
    .tick(preTick)
  );

  tcb_event_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .eventPin(eventPin),
    .fallPulse(evFall)
  );

  // Clock source choice; prescaler ignored in event mode
  assign countTick = running && (extClock ? evFall : preTick); // [RULE1] [RULE2] [RULE15]
  assign bound = boundMask(pwmOn, state_q.mode[2:1]); // [RULE9]
  assign overflow = countTick && hit(state_q.count, tcb_pkg::MASK_256, bound); // [RULE15]

  // Bus decode
  assign busReq = avmReq.read || avmReq.write;
  assign wordIdx = avmReq.address[tcb_pkg::ADDR_W-1:2];
  assign aligned = avmReq.address[1:0] == 2'b00;
  assign wrEn = avmReq.write && state_q.ack && aligned && avmReq.byteenable[0];
  assign wrByte = avmReq.writedata[7:0];

  always_comb
  begin
    state_d = state_q;
    state_d.runPrev = running;
    state_d.ack = busReq && !state_q.ack;

    // Read data captured in the request cycle
    state_d.rdata = '0;
    if (avmReq.read && aligned)
    begin
      if (wordIdx == tcb_pkg::IDX_MODE)
        state_d.rdata = {24'h000000, state_q.mode};
      else if (wordIdx == tcb_pkg::IDX_COUNT)
        state_d.rdata = {24'h000000, state_q.count};
      else if (wordIdx == tcb_pkg::IDX_FLAGS)
        state_d.rdata = {29'h0000000, state_q.pinFlag, state_q.ovfIen, state_q.ovfFlag};
    end

    // Counting and overflow handling
    if (overflow)
    begin
      state_d.reloadActive = state_q.reloadHold; // [RULE6]
      if (pwmOn)
        state_d.count = tcb_pkg::RST_BYTE; // [RULE19]
      else if (reloadOn)
        state_d.count = state_q.reloadHold; // [RULE5] [RULE10]
      else
        state_d.count = tcb_pkg::RST_BYTE; // [RULE15]
    end
    else if (countTick)
      state_d.count = state_q.count + 8'h01; // [RULE1]

    // Toggle output flips on each overflow
    if (overflow && toggleOn)
      state_d.toggleLvl = !state_q.toggleLvl; // [RULE11]

    // PWM: high from cycle start, low once count meets duty
    if ((running && !state_q.runPrev) || overflow)
      state_d.pwmLvl = 1'b1; // [RULE19]
    else if (running && hit(state_q.count, state_q.reloadActive, bound))
      state_d.pwmLvl = 1'b0; // [RULE19]

    // Software writes, applied at the edge where waitrequest is low
    if (wrEn)
    begin
      if (wordIdx == tcb_pkg::IDX_MODE)
        state_d.mode = wrByte;
      else if (wordIdx == tcb_pkg::IDX_COUNT)
        state_d.count = wrByte;
      else if (wordIdx == tcb_pkg::IDX_RELOAD)
      begin
        state_d.reloadHold = wrByte; // [RULE6]
        // While the timer is stopped the active copy follows too
        if (!running)
          state_d.reloadActive = wrByte;
      end
      else if (wordIdx == tcb_pkg::IDX_FLAGS)
      begin
        state_d.ovfIen = wrByte[tcb_pkg::FLG_IEN];
        if (wrByte[tcb_pkg::FLG_OVF])
          state_d.ovfFlag = 1'b0;
        if (wrByte[tcb_pkg::FLG_PIN])
          state_d.pinFlag = 1'b0;
      end
    end

    // Hardware set wins over software clear
    if (overflow)
      state_d.ovfFlag = 1'b1; // [RULE4] [RULE18]
    if (evFall && !extClock)
      state_d.pinFlag = 1'b1;
    if (extClock)
      state_d.pinFlag = 1'b0; // [RULE17]
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  // Combinational waitrequest: one wait cycle per access
  assign avmRsp.waitrequest = busReq && !state_q.ack;
  assign avmRsp.readdata = state_q.rdata;

  // Shared pin returns to GPIO as soon as both outputs are off
  always_comb
  begin
    if (pwmOn)
    begin
      sharedPin.level = state_q.pwmLvl; // [RULE13]
      sharedPin.drive = 1'b1;
    end
    else if (toggleOn)
    begin
      sharedPin.level = state_q.toggleLvl; // [RULE11]
      sharedPin.drive = 1'b1;
    end
    else
    begin
      sharedPin.level = gpio.gpioLevel; // [RULE12] [RULE13]
      sharedPin.drive = gpio.gpioDrive;
    end
  end

  assign overflowIrq = state_q.ovfFlag && state_q.ovfIen; // [RULE18]
  assign eventPinIrq = state_q.pinFlag; // [RULE17]
  // Only the event pin may wake; the timer overflow is left out on purpose
  assign wakeReq = evFall && !extClock; // [RULE16] [RULE20]

endmodule : tcb_timer

// [tcb_timer_properties.sv]
/* Port-level property checker for tcb_timer.
   Assumes one clock; mode and enable bits are mirrored from completed writes. */
`timescale 1ns/1ps
module tcb_timer_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bus
  input wire tcb_pkg::tcb_avm_req_t avmReq,
  input wire tcb_pkg::tcb_avm_rsp_t avmRsp,
  // Pins and requests
  input wire logic eventPin,
  input wire tcb_pkg::tcb_gpio_t gpio,
  input wire tcb_pkg::tcb_pin_t sharedPin,
  input wire logic overflowIrq,
  input wire logic eventPinIrq,
  input wire logic wakeReq
);
  logic [7:0] modeQ;
  logic ienQ;
  logic [3:0] quietQ;
  logic wrDone;
  assign wrDone = avmReq.write && !avmRsp.waitrequest && avmReq.byteenable[0];
  // Mirrors, since the design's own copies are not ports
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      modeQ <= 8'h00;
      ienQ <= 1'b0;
      quietQ <= 4'h0;
    end
    else
    begin
      if (wrDone && avmReq.address == 10'h368)
        modeQ <= avmReq.writedata[7:0];
      if (wrDone && avmReq.address == 10'h300)
        ienQ <= avmReq.writedata[1];
      quietQ <= $changed(eventPin) ? 4'h0 : ((quietQ == 4'hF) ? quietQ : quietQ + 4'h1);
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  AST_BUS_WAIT: assert property ($rose(avmReq.read || avmReq.write) |->
    avmRsp.waitrequest ##1 !avmRsp.waitrequest) else $error("bus wait not one cycle");
  AST_FLAG_HOLD: assert property (overflowIrq && !(wrDone && avmReq.address == 10'h300)
    |=> overflowIrq) else $error("overflow request dropped");
  AST_PWM_DRIVE: assert property (modeQ[0] |-> sharedPin.drive)
    else $error("pin not driven in pwm");
  AST_GPIO_PASS: assert property (modeQ[1:0] == 2'h0 |-> sharedPin == gpio)
    else $error("pin not handed to gpio");
  AST_EVT_NO_IRQ: assert property (modeQ[3] && $past(modeQ[3]) |-> !eventPinIrq)
    else $error("pin flag set in event mode");
  AST_EVT_NO_WAKE: assert property (modeQ[3] |-> !wakeReq)
    else $error("wake in event mode");
  AST_WAKE_CAUSE: assert property (wakeReq |-> quietQ < 4'h8)
    else $error("wake without pin edge");
  AST_PWM_FLAG: assert property (modeQ[0] && $past(modeQ[7], 2) && ienQ &&
    $rose(sharedPin.level) |-> overflowIrq) else $error("no request at pwm overflow");
endmodule : tcb_timer_properties

// [tcb_pulse_src.sv]
/* Pulse source on the event input pin.
   Assumes clk_sys; idles high, each phase lasts w cycles. */
`timescale 1ns/1ps
module tcb_pulse_src (
  // Clock
  input wire logic clk_sys,
  // Event pin
  output logic eventPin
);
  initial eventPin = 1'b1;
  // Two cycles a phase is the fastest the synchroniser accepts
  task send(input int n, input int w);
    repeat (n)
    begin
      eventPin <= 1'b0;
      repeat (w) @(posedge clk_sys);
      eventPin <= 1'b1;
      repeat (w) @(posedge clk_sys);
    end
  endtask : send
endmodule : tcb_pulse_src

// [tb_tcb_timer.sv]
/* Testbench for tcb_timer: registers, timed overflow, events, toggle, PWM.
   Assumes the pulse source model and the checker bound below. */
`timescale 1ns/1ps
module tb_tcb_timer;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  tcb_pkg::tcb_avm_req_t avmReq = '0;
  tcb_pkg::tcb_avm_rsp_t avmRsp;
  tcb_pkg::tcb_gpio_t gpio = 2'h1;
  tcb_pkg::tcb_pin_t sharedPin;
  logic eventPin, overflowIrq, eventPinIrq, wakeReq;
  logic [31:0] rd, keep;
  int fails = 0;
  int tests_run = 0;
  int cyc, hi, lo;
  int wakes = 0;
  always #2.5 clk_sys = ~clk_sys;
  // Wake pulses last one cycle, so they are counted rather than sampled
  always @(posedge clk_sys)
    if (wakeReq === 1'b1)
      wakes <= wakes + 1;
  tcb_timer tcb_timer_i (.clk_sys(clk_sys), .rst(rst), .avmReq(avmReq), .avmRsp(avmRsp),
    .eventPin(eventPin), .gpio(gpio), .sharedPin(sharedPin), .overflowIrq(overflowIrq),
    .eventPinIrq(eventPinIrq), .wakeReq(wakeReq));
  tcb_pulse_src tcb_pulse_src_i (.clk_sys(clk_sys), .eventPin(eventPin));
  task conclude;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic wr, input logic [9:0] adr, input logic [7:0] dat);
    int n;
    n = 0;
    avmReq <= '{read: !wr, write: wr, address: adr, writedata: {24'h000000, dat}, byteenable: 4'hF};
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avmRsp.waitrequest !== 1'b0 && n < 20);
    rd = avmRsp.readdata;
    avmReq <= '0;
    @(posedge clk_sys);
    if (n >= 20)
      chk(32'h0, 32'h1);
    if (n >= 20)
      conclude();
  endtask : bus
  // Bounded wait: for v high, until the overflow request rises; otherwise while the pin holds level v
  task span(input logic v, output int n);
    n = 0;
    while ((v ? overflowIrq !== 1'b1 : sharedPin.level === v) && n < 600)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 600)
      chk(32'h0, 32'h1);
    if (n >= 600)
      conclude();
  endtask : span
  task pinSpan(input logic v, output int n);
    n = 0;
    while (sharedPin.level === v && n < 100)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 100)
      chk(32'h0, 32'h1);
    if (n >= 100)
      conclude();
  endtask : pinSpan
  task scenRegs;
    bus(1, 10'h334, 8'h5A);
    bus(0, 10'h334, 8'h00);
    chk(rd, 32'h0);
    bus(1, 10'h3FC, 8'hFF);
    bus(0, 10'h3FC, 8'h00);
    chk(rd, 32'h0);
  endtask : scenRegs
  task scenTimer;
    bus(1, 10'h300, 8'h02);
    bus(1, 10'h36C, 8'hFF);
    bus(1, 10'h334, 8'hFF);
    bus(1, 10'h368, 8'h04);
    bus(1, 10'h368, 8'h84);
    bus(1, 10'h334, 8'h80);
    span(1'b1, cyc);
    chk(32'(cyc > 245 && cyc < 258), 32'h1);
    bus(0, 10'h36C, 8'h00);
    chk(rd, 32'h80);
    bus(0, 10'h300, 8'h00);
    chk(rd, 32'h3);
    bus(1, 10'h300, 8'h03);
    bus(0, 10'h300, 8'h00);
    chk(rd, 32'h2);
    bus(1, 10'h368, 8'h04);
    bus(0, 10'h36C, 8'h00);
    keep = rd;
    repeat (600) @(posedge clk_sys);
    bus(0, 10'h36C, 8'h00);
    chk(rd, keep);
  endtask : scenTimer
  task scenEvent;
    chk(wakes, 32'h0);
    tcb_pulse_src_i.send(1, 3);
    chk(eventPinIrq, 1'b1);
    chk(wakes, 32'h1);
    bus(1, 10'h300, 8'h06);
    bus(1, 10'h36C, 8'hFE);
    bus(1, 10'h334, 8'hFE);
    bus(1, 10'h368, 8'h7E);
    bus(1, 10'h368, 8'hFE);
    chk(sharedPin, 2'h1);
    tcb_pulse_src_i.send(2, 2);
    repeat (2) @(posedge clk_sys);
    chk(sharedPin, 2'h3);
    chk(overflowIrq, 1'b1);
    chk(eventPinIrq, 1'b0);
    bus(0, 10'h36C, 8'h00);
    chk(rd, 32'hFE);
    gpio <= 2'h2;
    bus(1, 10'h368, 8'hFC);
    chk(sharedPin, 2'h2);
    tcb_pulse_src_i.send(1, 5);
    bus(0, 10'h36C, 8'h00);
    chk(rd, 32'hFF);
    chk(wakes, 32'h1);
  endtask : scenEvent
  task scenPwm;
    bus(1, 10'h368, 8'h00);
    bus(1, 10'h334, 8'h04);
    bus(1, 10'h36C, 8'h00);
    // Clear the old overflow so the first PWM overflow must set it again
    bus(1, 10'h300, 8'h03);
    bus(1, 10'h368, 8'h77);
    bus(1, 10'h368, 8'hF7);
    pinSpan(1'b0, cyc);
    pinSpan(1'b1, cyc);
    pinSpan(1'b0, cyc);
    pinSpan(1'b1, hi);
    pinSpan(1'b0, lo);
    chk(32'(hi + lo), 32'h20);
    chk(32'(hi > 7 && hi < 11), 32'h1);
    chk(sharedPin.drive, 1'b1);
    // Resolution 32: reconfigure while stopped, then enable
    bus(1, 10'h368, 8'h75);
    bus(1, 10'h368, 8'hF5);
    pinSpan(1'b0, cyc);
    pinSpan(1'b1, cyc);
    pinSpan(1'b0, cyc);
    pinSpan(1'b1, hi);
    pinSpan(1'b0, lo);
    chk(32'(hi + lo), 32'h40);
    chk(32'(hi > 7 && hi < 11), 32'h1);
    bus(1, 10'h368, 8'h80);
    chk(sharedPin, 2'h2);
  endtask : scenPwm
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    scenRegs();
    scenTimer();
    scenEvent();
    scenPwm();
    conclude();
  end
endmodule : tb_tcb_timer
bind tcb_timer tcb_timer_properties tcb_timer_properties_i (.clk_sys(clk_sys), .rst(rst),
  .avmReq(avmReq), .avmRsp(avmRsp), .eventPin(eventPin), .gpio(gpio), .sharedPin(sharedPin),
  .overflowIrq(overflowIrq), .eventPinIrq(eventPinIrq), .wakeReq(wakeReq));
